/* conv_mode_regs.svh */
// Register map, field positions, reset values and timing constants
// Assumes inclusion by the mode/fault control logic and its package users
`ifndef CONV_MODE_REGS_SVH
`define CONV_MODE_REGS_SVH

// ==================================================
// Register offsets (8-bit address, 8-bit data)
`define ADDR_MODE_CONTROL     8'h00
`define ADDR_CONV_CONTROL     8'h01
`define ADDR_CONV_LEVELS      8'h02
`define ADDR_SLEEP_CONFIG     8'h03
`define ADDR_FAULT_CONFIG     8'h04
`define ADDR_FAULT_CAUSE_LOG  8'h05
`define ADDR_FAULT_STATUS     8'h06
`define ADDR_EVENT            8'h07
`define ADDR_EVENT_MASK       8'h08
`define ADDR_STATUS           8'h09

// ==================================================
// Field positions
`define MC_SLEEP              0
`define MC_SLEEP_PIN_EN       1
`define MC_INT_PIN_EN         2
`define CC_CONV_ENABLE        0
`define CC_FREQ_MODE_SEL      1
`define SC_AUTO_FREQ          0
`define SC_CONV_OFF           1
`define SC_IO_RAIL_OFF        2
`define FC_BOOT_TO_ACTIVE     2
`define LOG_SUPPLY_UV         0
`define LOG_OVERCURRENT       1
`define LOG_OVERTEMP          2
`define LOG_RAMPUP            3
`define LOG_POR               4
`define LOG_LONG_PRESS        5
`define LOG_SOFT_RESET        6
`define LOG_PWC               7
`define EV_SUPPLY_LOW_WARN    0
`define EV_OVERCURRENT_WARN   1

// ==================================================
// Reset values (also the configuration reloaded at each start-up)
`define RST_MODE_CONTROL      8'h04
`define RST_CONV_CONTROL      8'h01
`define RST_CONV_LEVELS       8'h00
`define RST_SLEEP_CONFIG      8'h00
`define RST_FAULT_CONFIG      8'h04
`define RST_EVENT_MASK        8'h00

// ==================================================
// Timing
`define CLK_KHZ               40000
`define RAMP_TIMEOUT_MS       20
`define FAULT_WAIT_UNIT_MS    5
`define UV_DEBOUNCE_US        30

`endif

/* conv_mode_pkg.sv */
// Types shared by the converter mode and fault control logic
// Assumes no other package; constants live in conv_mode_regs.svh
package conv_mode_pkg;

  typedef enum logic [5:0]
  {
    ST_OFF        = 6'h01,
    ST_POWER_DOWN = 6'h02,
    ST_LOAD       = 6'h04,
    ST_ACTIVE     = 6'h08,
    ST_SLEEP      = 6'h10,
    ST_FAULT      = 6'h20
  } sys_state_t;

  typedef enum logic [2:0]
  {
    CV_DOWN = 3'h1,
    CV_RAMP = 3'h2,
    CV_RUN  = 3'h4
  } conv_phase_t;

endpackage

/* converter_mode_fault_control.sv */
// System mode state machine, converter mode control and fault capture
// Assumes clk is the internal oscillator, sys_rst follows power-on reset,
// and an external serial slave drives the plain register port
//
// Summary of operation
// RULE1: Enabled converter runs fixed frequency when mode field 0, automatic when 1.
// RULE2: Automatic mode goes to DCM above drop level, back to CCM below hysteresis.
// RULE3: Master raises pair link enable when output falls below pair trigger level.
// RULE4: Master drops pair link enable when output rises above trigger plus hysteresis.
// RULE5: Master disabled drops pair link; slave shuts its converter down in response.
// RULE6: Power-down stops switching, paralleles caps, pulls down; restart needs output below 1 V.
// RULE7: Current limit disables converter, logs overcurrent, passes through fault recovery.
// RULE8: Alarm comparator raises overcurrent warning event; its state is readable.
// RULE9: Logic stays in reset while core supply is below low reset level.
// RULE10: At high reset level leave OFF for ACTIVE or POWER_DOWN by boot select.
// RULE11: POWER_DOWN keeps converter, oscillator, references off; wake press goes ACTIVE.
// RULE12: ACTIVE only after configuration load, then converter starts in configured mode.
// RULE13: Log records why ACTIVE was last entered; host reads it after start-up.
// RULE14: Sleep bit or sleep pin level controls SLEEP entry and return to ACTIVE.
// RULE15: Leaving SLEEP restores ACTIVE frequency mode and converter enable settings.
// RULE16: In SLEEP sleep_auto_freq set forces automatic mode; clear leaves it unchanged.
// RULE17: In SLEEP sleep_conv_off set disables converter; clear leaves enable unchanged.
// RULE18: In SLEEP sleep_io_rail_off set disables I/O rail; clear leaves it unchanged.
// RULE19: Fault recovery entered only from ACTIVE or SLEEP; no supervision in POWER_DOWN.
// RULE20: Fault recovery holds converter off for wait time, exits once fault gone.
// RULE21: Log bits clear on write of one; zero writes leave them unchanged.
// RULE22: Supply warning sets status and event; drives interrupt if unmasked and enabled.
// RULE23: Debounced under-voltage disables converter, logs; on recovery reloads and restarts.
// RULE24: No ramp within 20 ms logs ramp fault, passes fault recovery, powers up again.
// RULE25: Masks gate interrupt only; interrupt holds until all events cleared by ones.
// RULE26: All timing counts from the internal oscillator clock.
// RULE27: Every analog comparator input passes a two-flop synchroniser first.
`include "conv_mode_regs.svh"

module converter_mode_fault_control
#(
  parameter int RAMP_TIMEOUT_CYC    = `RAMP_TIMEOUT_MS * `CLK_KHZ,
  parameter int FAULT_WAIT_UNIT_CYC = `FAULT_WAIT_UNIT_MS * `CLK_KHZ
)
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       core_por_high,
  input  wire logic       otp_load_done,
  input  wire logic       wake_press,
  input  wire logic       long_press_cycle,
  input  wire logic       soft_reset_cycle,
  input  wire logic       pwc_cycle,
  input  wire logic       master_sel,
  input  wire logic       sleep_pin,
  input  wire logic       pair_link_in,
  input  wire logic       cmp_above_drop,
  input  wire logic       cmp_below_drop_hyst,
  input  wire logic       cmp_below_pair_trigger,
  input  wire logic       cmp_above_pair_release,
  input  wire logic       cmp_out_below_1v,
  input  wire logic       cmp_out_ramped,
  input  wire logic       cmp_current_limit,
  input  wire logic       cmp_oc_alarm,
  input  wire logic       cmp_supply_warn,
  input  wire logic       cmp_supply_uv,
  input  wire logic       cmp_supply_recovered,
  input  wire logic       cmp_temp_crit,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            conv_switching,
  output logic            conv_caps_parallel,
  output logic            conv_pulldown,
  output logic            conv_auto_mode,
  output logic            conv_dcm,
  output logic      [3:0] pair_trigger_drop,
  output logic      [1:0] pair_release_hyst,
  output logic      [1:0] conv_current_limit_sel,
  output logic            pair_link_out,
  output logic            osc_enable,
  output logic            ref_enable,
  output logic            io_rail_enable,
  output logic            interrupt_out_n
);
  import conv_mode_pkg::*;

  // ==================================================
  // Helpers
  function automatic logic [7:0] w1c_next(input logic [7:0] cur, input logic [7:0] set,
                                          input logic clr_en, input logic [7:0] data);
    w1c_next = (cur & ~(clr_en ? data : 8'h00)) | set;
  endfunction

  localparam logic [23:0] RAMP_LAST = 24'(RAMP_TIMEOUT_CYC - 1);
  localparam logic [15:0] UV_DEB_LAST = 16'(`UV_DEBOUNCE_US * `CLK_KHZ / 1000 - 1);

  // ==================================================
  // Synchronisers: every comparator input and every pin except clk, sys_rst, the three power-cycle strobes and the register port
  logic [17:0] sync1;
  logic [17:0] sync2;
  wire  [17:0] async_in = {core_por_high, master_sel, sleep_pin, pair_link_in, cmp_above_drop,
                           cmp_below_drop_hyst, cmp_below_pair_trigger, cmp_above_pair_release,
                           cmp_out_below_1v, cmp_out_ramped, cmp_current_limit, cmp_oc_alarm,
                           cmp_supply_warn, cmp_supply_uv, cmp_supply_recovered, cmp_temp_crit,
                           wake_press, otp_load_done};
  wire por_high_s, master_s, sleep_pin_s, pair_in_s, above_drop_s, below_hyst_s;
  wire below_trig_s, above_rel_s, below_1v_s, ramped_s, ilim_s, oc_alarm_s;
  wire supply_warn_s, supply_uv_s, supply_rec_s, temp_crit_s, wake_s, otp_done_s;
  assign {por_high_s, master_s, sleep_pin_s, pair_in_s, above_drop_s, below_hyst_s,
          below_trig_s, above_rel_s, below_1v_s, ramped_s, ilim_s, oc_alarm_s,
          supply_warn_s, supply_uv_s, supply_rec_s, temp_crit_s, wake_s, otp_done_s} = sync2;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sync1 <= 18'h00000;
      sync2 <= 18'h00000;
    end
    else
    begin
      sync1 <= async_in;  // RULE27
      sync2 <= sync1;
    end
  end

  // ==================================================
  // Registers
  logic [7:0] mode_control;
  logic [7:0] conv_control;
  logic [7:0] conv_levels;
  logic [7:0] sleep_config;
  logic [7:0] fault_config;
  logic [7:0] fault_cause_log;
  logic [7:0] event_flags;
  logic [7:0] event_mask;
  logic       supply_warn_d;
  logic       oc_alarm_d;

  sys_state_t  state;
  sys_state_t  next_state;
  conv_phase_t phase;
  conv_phase_t next_phase;

  wire sleep_bit       = mode_control[`MC_SLEEP];
  wire sleep_pin_en    = mode_control[`MC_SLEEP_PIN_EN];
  wire int_pin_en      = mode_control[`MC_INT_PIN_EN];
  wire sleep_auto_freq = sleep_config[`SC_AUTO_FREQ];
  wire sleep_conv_off  = sleep_config[`SC_CONV_OFF];
  wire sleep_io_off    = sleep_config[`SC_IO_RAIL_OFF];
  wire in_active       = (state == ST_ACTIVE);
  wire in_sleep        = (state == ST_SLEEP);
  wire supervised      = in_active | in_sleep;  // RULE19
  wire wr_hit_log      = reg_wr & (reg_addr == `ADDR_FAULT_CAUSE_LOG);
  wire wr_hit_event    = reg_wr & (reg_addr == `ADDR_EVENT);
  wire reload_cfg      = (state == ST_LOAD);

  // Sleep only overrides effective values; the registers keep ACTIVE settings
  wire eff_enable   = (in_active & conv_control[`CC_CONV_ENABLE])
                    | (in_sleep & conv_control[`CC_CONV_ENABLE] & ~sleep_conv_off);  // RULE17 RULE15 RULE12
  wire eff_auto     = (in_sleep & sleep_auto_freq) | conv_control[`CC_FREQ_MODE_SEL];  // RULE1 RULE16 RULE15
  wire slave_gate   = master_s | pair_in_s;  // RULE5
  wire conv_req     = eff_enable & slave_gate;
  wire sleep_want   = sleep_bit | (sleep_pin_en & sleep_pin_s);  // RULE14

  always_ff @(posedge clk)
  begin
    if (sys_rst | reload_cfg)
    begin
      mode_control <= `RST_MODE_CONTROL;
      conv_control <= `RST_CONV_CONTROL;
      conv_levels  <= `RST_CONV_LEVELS;
      sleep_config <= `RST_SLEEP_CONFIG;
      fault_config <= `RST_FAULT_CONFIG;
      event_mask   <= `RST_EVENT_MASK;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `ADDR_MODE_CONTROL)
        mode_control <= reg_wdata;
      if (reg_addr == `ADDR_CONV_CONTROL)
        conv_control <= reg_wdata;
      if (reg_addr == `ADDR_CONV_LEVELS)
        conv_levels <= reg_wdata;
      if (reg_addr == `ADDR_SLEEP_CONFIG)
        sleep_config <= reg_wdata;
      if (reg_addr == `ADDR_FAULT_CONFIG)
        fault_config <= reg_wdata;
      if (reg_addr == `ADDR_EVENT_MASK)
        event_mask <= reg_wdata;
    end
  end

  // ==================================================
  // Fault detection
  logic [15:0] uv_deb_cnt;
  logic [23:0] ramp_cnt;
  logic [23:0] wait_cnt;
  logic        uv_latched;

  wire uv_deb_done  = supply_uv_s & (uv_deb_cnt == UV_DEB_LAST);
  wire ramp_fail    = (phase == CV_RAMP) & (ramp_cnt == RAMP_LAST) & ~ramped_s;  // RULE24 RULE26
  wire uv_fault     = supervised & uv_deb_done;  // RULE23
  wire ilim_fault   = supervised & ilim_s & (phase == CV_RUN);  // RULE7
  wire temp_fault   = supervised & temp_crit_s;
  wire any_fault    = uv_fault | ilim_fault | temp_fault | (supervised & ramp_fail);
  wire [23:0] wait_limit = 24'((32'(fault_config[1:0]) + 32'h1) * 32'(FAULT_WAIT_UNIT_CYC));
  wire wait_done    = (wait_cnt >= wait_limit - 24'h1);
  wire fault_gone   = ~temp_crit_s & (~uv_latched | supply_rec_s);  // RULE23
  wire power_cycle  = long_press_cycle | soft_reset_cycle | pwc_cycle;
  wire leave_off    = (state == ST_OFF) & por_high_s;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      uv_deb_cnt <= 16'h0000;
    else if (~supply_uv_s)
      uv_deb_cnt <= 16'h0000;
    else if (~uv_deb_done)
      uv_deb_cnt <= uv_deb_cnt + 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst | (phase != CV_RAMP))
      ramp_cnt <= 24'h000000;
    else if (ramp_cnt != RAMP_LAST)
      ramp_cnt <= ramp_cnt + 24'h000001;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst | (state != ST_FAULT))
      wait_cnt <= 24'h000000;
    else if (~wait_done)
      wait_cnt <= wait_cnt + 24'h000001;  // RULE20 RULE26
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      uv_latched <= 1'b0;
    else if (uv_fault)
      uv_latched <= 1'b1;
    else if (state != ST_FAULT)
      uv_latched <= 1'b0;
  end

  // ==================================================
  // System mode state machine
  always_comb
  begin
    next_state = state;
    case (state)
      ST_OFF:
        if (por_high_s)
          next_state = fault_config[`FC_BOOT_TO_ACTIVE] ? ST_LOAD : ST_POWER_DOWN;  // RULE10
      ST_POWER_DOWN:
        if (wake_s)
          next_state = ST_LOAD;  // RULE11
      ST_LOAD:
        if (otp_done_s)
          next_state = ST_ACTIVE;  // RULE12
      ST_ACTIVE:
        if (any_fault)
          next_state = ST_FAULT;
        else if (power_cycle)
          next_state = ST_LOAD;
        else if (sleep_want)
          next_state = ST_SLEEP;  // RULE14
      ST_SLEEP:
        if (any_fault)
          next_state = ST_FAULT;
        else if (power_cycle)
          next_state = ST_LOAD;
        else if (~sleep_want)
          next_state = ST_ACTIVE;  // RULE14 RULE15
      ST_FAULT:
        if (wait_done & fault_gone)
          next_state = ST_LOAD;  // RULE20 RULE23 RULE24 RULE7
      default:
        next_state = ST_OFF;
    endcase
  end

  // Held in OFF by sys_rst, which tracks the low supply level
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state <= ST_OFF;  // RULE9
    else
      state <= next_state;
  end

  // ==================================================
  // Converter phase: restart refused until output has fallen below 1 V
  logic below_1v_seen;

  always_comb
  begin
    next_phase = phase;
    case (phase)
      CV_DOWN:
        if (conv_req & below_1v_seen)
          next_phase = CV_RAMP;  // RULE6
      CV_RAMP:
        if (~conv_req | ramp_fail)
          next_phase = CV_DOWN;
        else if (ramped_s)
          next_phase = CV_RUN;
      CV_RUN:
        if (~conv_req | ilim_fault | uv_fault | temp_fault)
          next_phase = CV_DOWN;  // RULE7 RULE23 RULE5
      default:
        next_phase = CV_DOWN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      phase         <= CV_DOWN;
      below_1v_seen <= 1'b0;
    end
    else
    begin
      phase         <= next_phase;
      below_1v_seen <= (phase == CV_DOWN) & (below_1v_seen | below_1v_s);  // RULE6
    end
  end

  // ==================================================
  // Fault log, events and status
  logic [7:0] log_set;
  logic [7:0] ev_set;

  always_comb
  begin
    log_set                   = 8'h00;
    log_set[`LOG_SUPPLY_UV]   = uv_fault;  // RULE23
    log_set[`LOG_OVERCURRENT] = ilim_fault;  // RULE7
    log_set[`LOG_OVERTEMP]    = temp_fault;
    log_set[`LOG_RAMPUP]      = supervised & ramp_fail;  // RULE24
    log_set[`LOG_POR]         = leave_off;  // RULE13
    log_set[`LOG_LONG_PRESS]  = supervised & long_press_cycle;
    log_set[`LOG_SOFT_RESET]  = supervised & soft_reset_cycle;
    log_set[`LOG_PWC]         = supervised & pwc_cycle;
    ev_set                    = 8'h00;
    ev_set[`EV_SUPPLY_LOW_WARN]  = supervised & supply_warn_s & ~supply_warn_d;  // RULE22
    ev_set[`EV_OVERCURRENT_WARN] = supervised & oc_alarm_s & ~oc_alarm_d;  // RULE8
  end

  // Set wins over a simultaneous write-one clear
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      fault_cause_log <= 8'h00;
      event_flags     <= 8'h00;
      supply_warn_d   <= 1'b0;
      oc_alarm_d      <= 1'b0;
    end
    else
    begin
      fault_cause_log <= w1c_next(fault_cause_log, log_set, wr_hit_log, reg_wdata);  // RULE21 RULE13
      event_flags     <= w1c_next(event_flags, ev_set, wr_hit_event, reg_wdata);  // RULE25
      supply_warn_d   <= supply_warn_s;
      oc_alarm_d      <= oc_alarm_s;
    end
  end

  // ==================================================
  // Pair link and CCM/DCM selection
  logic pair_en;
  logic dcm;

  always_ff @(posedge clk)
  begin
    if (sys_rst | ~master_s | (phase != CV_RUN))
      pair_en <= 1'b0;  // RULE5
    else if (below_trig_s)
      pair_en <= 1'b1;  // RULE3
    else if (above_rel_s)
      pair_en <= 1'b0;  // RULE4
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst | ~eff_auto | (phase != CV_RUN))
      dcm <= 1'b0;  // RULE1
    else if (above_drop_s)
      dcm <= 1'b1;  // RULE2
    else if (below_hyst_s)
      dcm <= 1'b0;  // RULE2
  end

  // ==================================================
  // Read mux and registered outputs
  wire [7:0] status_rd = {5'h00, pair_en, dcm, supply_warn_s};
  wire [7:0] rd_mux =
      (reg_addr == `ADDR_MODE_CONTROL)    ? mode_control :
      (reg_addr == `ADDR_CONV_CONTROL)    ? conv_control :
      (reg_addr == `ADDR_CONV_LEVELS)     ? conv_levels :
      (reg_addr == `ADDR_SLEEP_CONFIG)    ? sleep_config :
      (reg_addr == `ADDR_FAULT_CONFIG)    ? fault_config :
      (reg_addr == `ADDR_FAULT_CAUSE_LOG) ? fault_cause_log :
      (reg_addr == `ADDR_FAULT_STATUS)    ? {7'h00, oc_alarm_s} :  // RULE8
      (reg_addr == `ADDR_EVENT)           ? event_flags :
      (reg_addr == `ADDR_EVENT_MASK)      ? event_mask :
      (reg_addr == `ADDR_STATUS)          ? status_rd : 8'h00;
  wire irq_any = |(event_flags & ~event_mask);  // RULE25 RULE22
  wire osc_on  = ~(state == ST_OFF) & ~(state == ST_POWER_DOWN);  // RULE11

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      reg_rdata              <= 8'h00;
      conv_switching         <= 1'b0;
      conv_caps_parallel     <= 1'b1;
      conv_pulldown          <= 1'b1;
      conv_auto_mode         <= 1'b0;
      conv_dcm               <= 1'b0;
      pair_trigger_drop      <= 4'h0;
      pair_release_hyst      <= 2'h0;
      conv_current_limit_sel <= 2'h0;
      pair_link_out          <= 1'b0;
      osc_enable             <= 1'b0;
      ref_enable             <= 1'b0;
      io_rail_enable         <= 1'b0;
      interrupt_out_n        <= 1'b1;
    end
    else
    begin
      reg_rdata              <= rd_mux;
      conv_switching         <= (phase == CV_RUN);  // RULE6
      conv_caps_parallel     <= (phase != CV_RUN);  // RULE6
      conv_pulldown          <= (phase == CV_DOWN);  // RULE6
      conv_auto_mode         <= eff_auto;  // RULE1 RULE16
      conv_dcm               <= dcm;
      pair_trigger_drop      <= conv_levels[3:0];
      pair_release_hyst      <= conv_levels[5:4];
      conv_current_limit_sel <= conv_levels[7:6];
      pair_link_out          <= pair_en;
      osc_enable             <= osc_on;
      ref_enable             <= osc_on;
      io_rail_enable         <= in_active | (in_sleep & ~sleep_io_off);  // RULE18
      interrupt_out_n        <= ~(irq_any & int_pin_en);  // RULE22
    end
  end

endmodule

/* conv_mode_sva.sv */
// Port checker for the converter mode and fault control block
// Assumes it is bound onto the top module and sees only its ports
module conv_mode_sva
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic master_sel,
  input wire logic cmp_below_pair_trigger,
  input wire logic cmp_above_pair_release,
  input wire logic cmp_current_limit,
  input wire logic conv_switching,
  input wire logic conv_caps_parallel,
  input wire logic conv_pulldown,
  input wire logic conv_auto_mode,
  input wire logic conv_dcm,
  input wire logic pair_link_out,
  input wire logic interrupt_out_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==================================================
  // Properties
  property p_rst; $fell(sys_rst) |-> interrupt_out_n && !conv_switching && !pair_link_out; endproperty
  property p_fix; !conv_auto_mode [*2] |-> !conv_dcm; endproperty
  property p_dcm; $rose(conv_dcm) |-> conv_auto_mode; endproperty
  // Six cycles cover the synchroniser and the output flop
  property p_pon; (master_sel && cmp_below_pair_trigger && conv_switching) [*6] |-> pair_link_out; endproperty
  property p_poff; (cmp_above_pair_release && !cmp_below_pair_trigger) [*6] |-> !pair_link_out; endproperty
  property p_sd; !conv_switching [*3] |-> !pair_link_out; endproperty
  property p_cap; !conv_switching [*2] |-> conv_caps_parallel; endproperty
  property p_pd; conv_switching |-> !conv_pulldown; endproperty
  property p_ilim; $rose(cmp_current_limit) && conv_switching |-> ##[1:5] !conv_switching; endproperty
  a_rst: assert property (p_rst) else $error("reset not idle");
  a_fix: assert property (p_fix) else $error("fixed dcm");
  a_dcm: assert property (p_dcm) else $error("dcm no auto");
  a_pon: assert property (p_pon) else $error("pair not on");
  a_poff: assert property (p_poff) else $error("pair not off");
  a_sd: assert property (p_sd) else $error("pair while off");
  a_cap: assert property (p_cap) else $error("caps idle");
  a_pd: assert property (p_pd) else $error("pulldown on");
  a_ilim: assert property (p_ilim) else $error("ilim ignored");
  c_dcm: cover property ($rose(conv_dcm));
  c_irq: cover property ($fell(interrupt_out_n));
  c_off: cover property ($fell(conv_switching));
endmodule

bind converter_mode_fault_control conv_mode_sva u_sva (.*);

/* pair_slave_model.sv */
// Paired slave converter seen from the master's pair link
// Assumes one clock shared with the master
module pair_slave_model
(
  input  wire logic clk,
  input  wire logic pair_link_out,
  output logic      slave_on
);
  timeunit 1ns;
  timeprecision 1ps;
  // Slave runs only while enabled; drop of the link shuts it down
  always_ff @(posedge clk)
    slave_on <= pair_link_out;
endmodule

/* tb_top.sv */
// Bench: boot, modes, pair link, sleep, events, faults, power cycles
// Assumes the design, the checker and the slave model compile first
`include "conv_mode_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, core_por_high, otp_load_done, wake_press, long_press_cycle, soft_reset_cycle, pwc_cycle;
  logic master_sel, sleep_pin, pair_link_in, cmp_above_drop, cmp_below_drop_hyst, cmp_below_pair_trigger;
  logic cmp_above_pair_release, cmp_out_below_1v, cmp_out_ramped, cmp_current_limit, cmp_oc_alarm;
  logic cmp_supply_warn, cmp_supply_uv, cmp_supply_recovered, cmp_temp_crit, reg_wr, rq, rq_d, slave_on;
  logic conv_switching, conv_caps_parallel, conv_pulldown, conv_auto_mode, conv_dcm, pair_link_out;
  logic osc_enable, ref_enable, io_rail_enable, interrupt_out_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, lv;
  logic [3:0] pair_trigger_drop;
  logic [1:0] pair_release_hyst, conv_current_limit_sel;
  logic [7:0] exp_q[$];
  int         fails, checked, i, n;

  converter_mode_fault_control #(.RAMP_TIMEOUT_CYC(200), .FAULT_WAIT_UNIT_CYC(50)) u_dut (.*);
  pair_slave_model u_slave (.*);

  // ==================================================
  // Tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] expv);
    checked++;
    if (seen !== expv)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  // Expected value is queued; the monitor compares two edges later
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    rq <= 1'h1;
    exp_q.push_back(e);
    @(posedge clk);
    rq <= 1'h0;
    @(posedge clk);
  endtask
  task automatic settle;
    repeat (8) @(posedge clk);
  endtask
  task automatic wait_sw(input logic v);
    n = 0;
    while (conv_switching !== v && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    chk(conv_switching, v);
  endtask
  task automatic summarize;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk)
  begin
    rq_d <= rq;
    if (rq_d === 1'h1)
      chk(reg_rdata, exp_q.pop_front());
  end
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    #1000000;
    fails++;
    summarize();
  end

  // ==================================================
  // Main sequence
  initial
  begin
    {core_por_high, otp_load_done, wake_press, long_press_cycle, soft_reset_cycle, pwc_cycle, master_sel,
     sleep_pin, pair_link_in, cmp_above_drop, cmp_below_drop_hyst, cmp_below_pair_trigger,
     cmp_above_pair_release, cmp_out_below_1v, cmp_out_ramped, cmp_current_limit, cmp_oc_alarm,
     cmp_supply_warn, cmp_supply_uv, cmp_supply_recovered, cmp_temp_crit, reg_wr, rq, rq_d} = '0;
    {reg_addr, reg_wdata} = '0;
    sys_rst = 1'h1;
    void'($urandom(64388));
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    settle();
    chk({interrupt_out_n, osc_enable}, 2'h2);
    rd_reg(`ADDR_SLEEP_CONFIG, `RST_SLEEP_CONFIG);
    {core_por_high, master_sel} <= 2'h3;
    otp_load_done <= 1'h1;
    cmp_out_below_1v <= 1'h1;
    cmp_out_ramped <= 1'h1;
    wait_sw(1'h1);
    chk({conv_auto_mode, osc_enable, ref_enable}, 3'h3);
    rd_reg(`ADDR_FAULT_CAUSE_LOG, 8'h10);
    wr_reg(`ADDR_FAULT_CAUSE_LOG, 8'h00);
    rd_reg(`ADDR_FAULT_CAUSE_LOG, 8'h10);
    wr_reg(`ADDR_FAULT_CAUSE_LOG, 8'h10);
    rd_reg(`ADDR_FAULT_CAUSE_LOG, 8'h00);
    lv = 8'($urandom);
    wr_reg(`ADDR_CONV_LEVELS, lv);
    wr_reg(8'h0F, lv);
    rd_reg(8'h0F, 8'h00);
    settle();
    chk({conv_current_limit_sel, pair_release_hyst, pair_trigger_drop}, lv);
    $display("boot done");
    wr_reg(`ADDR_CONV_CONTROL, 8'h03);
    cmp_above_drop <= 1'h1;
    settle();
    chk({conv_auto_mode, conv_dcm}, 2'h3);
    cmp_above_drop <= 1'h0;
    cmp_below_drop_hyst <= 1'h1;
    settle();
    chk(conv_dcm, 1'h0);
    cmp_below_drop_hyst <= 1'h0;
    wr_reg(`ADDR_CONV_CONTROL, 8'h01);
    cmp_below_pair_trigger <= 1'h1;
    settle();
    chk(pair_link_out, 1'h1);
    cmp_below_pair_trigger <= 1'h0;
    cmp_above_pair_release <= 1'h1;
    settle();
    chk(pair_link_out, 1'h0);
    cmp_above_pair_release <= 1'h0;
    cmp_below_pair_trigger <= 1'h1;
    $display("mode done");
    for (i = 0; i < 2; i++)
    begin
      wr_reg(`ADDR_SLEEP_CONFIG, (i == 1) ? 8'h02 : 8'h05);
      wr_reg(`ADDR_MODE_CONTROL, 8'h05);
      settle();
      chk({conv_auto_mode, io_rail_enable, conv_switching, slave_on}, (i == 1) ? 4'h4 : 4'hB);
      wr_reg(`ADDR_MODE_CONTROL, 8'h04);
      wait_sw(1'h1);
      settle();
      chk({conv_auto_mode, io_rail_enable}, 2'h1);
    end
    $display("sleep done");
    cmp_supply_warn <= 1'h1;
    cmp_oc_alarm <= 1'h1;
    settle();
    chk(interrupt_out_n, 1'h0);
    rd_reg(`ADDR_EVENT, 8'h03);
    rd_reg(`ADDR_FAULT_STATUS, 8'h01);
    rd_reg(`ADDR_STATUS, 8'h05);
    wr_reg(`ADDR_EVENT_MASK, 8'h03);
    settle();
    chk(interrupt_out_n, 1'h1);
    rd_reg(`ADDR_EVENT, 8'h03);
    wr_reg(`ADDR_EVENT_MASK, 8'h00);
    wr_reg(`ADDR_EVENT, 8'h01);
    settle();
    chk(interrupt_out_n, 1'h0);
    wr_reg(`ADDR_EVENT, 8'h02);
    settle();
    chk(interrupt_out_n, 1'h1);
    cmp_supply_warn <= 1'h0;
    cmp_oc_alarm <= 1'h0;
    $display("event done");
    cmp_current_limit <= 1'h1;
    wait_sw(1'h0);
    cmp_current_limit <= 1'h0;
    wait_sw(1'h1);
    chk(8'(n >= 50), 8'h01);
    rd_reg(`ADDR_FAULT_CAUSE_LOG, 8'h02);
    cmp_temp_crit <= 1'h1;
    wait_sw(1'h0);
    repeat (200) @(posedge clk);
    chk(conv_switching, 1'h0);
    cmp_temp_crit <= 1'h0;
    wait_sw(1'h1);
    rd_reg(`ADDR_FAULT_CAUSE_LOG, 8'h06);
    $display("fault done");
    for (i = 0; i < 3; i++)
    begin
      wr_reg(`ADDR_FAULT_CAUSE_LOG, 8'hFF);
      {pwc_cycle, soft_reset_cycle, long_press_cycle} <= 3'(1 << i);
      @(posedge clk);
      {pwc_cycle, soft_reset_cycle, long_press_cycle} <= 3'h0;
      wait_sw(1'h0);
      wait_sw(1'h1);
      rd_reg(`ADDR_FAULT_CAUSE_LOG, 8'(8'h20 << i));
    end
    $display("cycle done");
    summarize();
  end
endmodule
